// file: core/turbo_codec_pkg.sv
package turbo_codec_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes and lengths
  localparam int ADDR_W = 14;
  localparam int SLOTS = 6;
  localparam int MAX_PERIODS = 12;
  localparam int PUNCT_IDS = 12;
  localparam int TAIL_PERIODS = 6;
  localparam int TAIL_HALF = 3;
  localparam int TAIL_BITS = 6;
  localparam int PRBS_W = 15;
  localparam int PRBS_TAP_A = 1;
  localparam int PRBS_TAP_B = 0;

  typedef logic [ADDR_W-1:0] addr_t;

  localparam addr_t LEN_DATA = 14'h2ffa;
  localparam addr_t LEN_SIG = 14'h047a;
  localparam int MEM_DEPTH = 12282;
  localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h4a80;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] TAIL_LAST = 3'h5;
  localparam logic [3:0] PUNCT_DEFAULT = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers and states
  typedef struct packed {
    logic data;
    logic start;
  } in_beat_s;

  typedef struct packed {
    logic data;
    logic start;
  } out_sym_s;

  typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_DATA, PH_TAIL} phase_e;

  ////////////////////////////////////////////////////////////////////////////////
  // puncturing tables, period 0 in the top field, slot order x y0 y1 x' y0' y1'
  localparam logic [71:0] DATA_PUNCT [PUNCT_IDS] = '{
    {6'h3b, 66'h0},
    {6'h2b, 6'h3b, 6'h39, 6'h3b, 48'h0},
    {6'h39, 6'h33, 60'h0},
    {6'h29, 6'h2b, 6'h29, 6'h39, 48'h0},
    {6'h32, 66'h0},
    {6'h29, 66'h0},
    {6'h20, 6'h24, 6'h20, 6'h29, 6'h29, 6'h09, 6'h29, 6'h29, 6'h09, 6'h29, 6'h29, 6'h09},
    {6'h32, 6'h12, 6'h32, 6'h32, 6'h12, 6'h20, 6'h32, 6'h12, 6'h32, 6'h32, 6'h12, 6'h32},
    {6'h30, 6'h22, 60'h0},
    {6'h22, 6'h30, 60'h0},
    {6'h20, 6'h20, 6'h20, 6'h28, 48'h0},
    {6'h20, 6'h29, 6'h20, 6'h20, 48'h0}
  };

  localparam logic [3:0] DATA_PERIODS [PUNCT_IDS] = '{
    4'h1, 4'h4, 4'h2, 4'h4, 4'h1, 4'h1, 4'hc, 4'hc, 4'h2, 4'h2, 4'h4, 4'h4
  };

  // tail: three 2-bit copy counts per period, for the clocked encoder only
  localparam logic [35:0] TAIL_PUNCT [PUNCT_IDS] = '{
    {6'h35, 6'h35, 6'h35, 6'h35, 6'h35, 6'h35},
    {6'h35, 6'h35, 6'h25, 6'h25, 6'h25, 6'h35},
    {6'h25, 6'h25, 6'h25, 6'h25, 6'h25, 6'h25},
    {6'h15, 6'h25, 6'h25, 6'h25, 6'h15, 6'h15},
    {6'h24, 6'h24, 6'h24, 6'h24, 6'h24, 6'h24},
    {6'h21, 6'h21, 6'h21, 6'h21, 6'h21, 6'h21},
    {6'h15, 6'h15, 6'h11, 6'h15, 6'h15, 6'h11},
    {6'h15, 6'h14, 6'h15, 6'h15, 6'h14, 6'h15},
    {6'h14, 6'h14, 6'h14, 6'h14, 6'h14, 6'h14},
    {6'h11, 6'h11, 6'h11, 6'h11, 6'h11, 6'h11},
    {6'h15, 6'h15, 6'h15, 6'h15, 6'h15, 6'h15},
    {6'h15, 6'h15, 6'h15, 6'h15, 6'h15, 6'h15}
  };

  // copies of one candidate symbol in the given period
  function automatic logic [1:0] slot_count(
    input logic tail,
    input logic [3:0] sel,
    input logic [3:0] pos,
    input logic [2:0] slot
  );
    int bp;
    logic [1:0] cnt;
    bp = 0;
    cnt = 2'h0;
    if (!tail)
    begin
      bp = SLOTS * MAX_PERIODS - 1 - SLOTS * int'(pos) - int'(slot);
      cnt = {1'b0, DATA_PUNCT[sel][bp]};
    end
    else if ((int'(pos) < TAIL_HALF) == (int'(slot) < TAIL_HALF))
    begin
      bp = SLOTS * TAIL_PERIODS - 1 - SLOTS * int'(pos) - 2 * (int'(slot) % TAIL_HALF);
      cnt = TAIL_PUNCT[sel][bp -: 2];
    end
    return cnt;
  endfunction

endpackage

// file: core/prbs_scrambler.sv
module prbs_scrambler (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic step,
  output logic prbs_bit
);

  logic [turbo_codec_pkg::PRBS_W-1:0] stages;
  logic [turbo_codec_pkg::PRBS_W-1:0] cur;

  // seed takes effect for the very bit that starts the frame
  assign cur = load ? turbo_codec_pkg::PRBS_SEED : stages;
  assign prbs_bit = cur[turbo_codec_pkg::PRBS_TAP_A] ^ cur[turbo_codec_pkg::PRBS_TAP_B];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      stages <= 15'h0000;
    else if (step)
      stages <= {prbs_bit, cur[turbo_codec_pkg::PRBS_W-1:1]};
    else if (load)
      stages <= turbo_codec_pkg::PRBS_SEED;
  end

endmodule

// file: core/rsc_encoder.sv
module rsc_encoder (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic step,
  input wire logic terminate,
  input wire logic data_in,
  output logic sym_x,
  output logic parity_a_out,
  output logic parity_b_out
);

  // st[0] is one delay, st[2] three delays
  logic [2:0] st;
  logic u;
  logic w;

  // in termination the input is the feedback, so the register drains to zero
  assign u = terminate ? (st[1] ^ st[2]) : data_in;
  assign w = u ^ st[1] ^ st[2];
  assign sym_x = u;
  assign parity_a_out = w ^ st[0] ^ st[2];
  assign parity_b_out = w ^ st[0] ^ st[1] ^ st[2];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= 3'h0;
    else if (clear)
      st <= 3'h0;
    else if (step)
      st <= {st[1], st[0], w};
  end

endmodule

// file: core/frame_scrambler_turbo_encoder.sv
// What this block does
// - scramble every stream frame bit, msb first, block length
// - prbs from 15 stages, 1+x^14+x^15
// - load fixed seed at each frame start
// - two equal encoders, second sees interleaved order
// - output count is (length+6)/rate
// - stream frames use 12282 bit blocks
// - signalling content uses 1146 bit blocks
// - feedback 1+d2+d3, parities 1+d+d3, 1+d+d2+d3
// - clear both encoder states before each block
// - clock encoders once per data bit, puncture
// - emit x y0 y1 x' y0' y1' in order
// - zero suppresses a candidate, one passes it
// - no repeated symbols in data periods
// - walk pattern rows cyclically across bit periods
// - selector 0 to 11 picks the pattern
// - short data puncturing is padded by tail symbols
// - terminate encoder one, then encoder two, thrice
// - tail entries 2 or 3 repeat the symbol
module frame_scrambler_turbo_encoder (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic signalling_mode,
  input wire logic [3:0] puncture_pattern_select,
  input wire logic in_valid,
  output logic in_ready,
  input wire turbo_codec_pkg::in_beat_s in_beat,
  output logic out_valid,
  input wire logic out_ready,
  output turbo_codec_pkg::out_sym_s out_sym,
  output turbo_codec_pkg::addr_t perm_index,
  input wire turbo_codec_pkg::addr_t perm_addr,
  output logic block_done
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  turbo_codec_pkg::phase_e phase;
  turbo_codec_pkg::addr_t turbo_block_length;
  turbo_codec_pkg::addr_t wr_idx;
  turbo_codec_pkg::addr_t bit_idx;
  logic [3:0] pattern_sel;
  logic [3:0] pattern_pos;
  logic [2:0] tail_pos;
  logic [2:0] slot;
  logic [1:0] rep;
  logic scramble_on;
  logic first_sym;

  logic frame_bits [turbo_codec_pkg::MEM_DEPTH];

  // true on the final bit index of a block
  function automatic logic is_last(
    input turbo_codec_pkg::addr_t idx,
    input turbo_codec_pkg::addr_t len
  );
    return idx == len - 14'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // input side

  logic accept;
  logic frame_start;
  logic load_bit;
  logic last_in;
  logic prbs_bit;
  logic scramble_eff;
  logic scrambled;
  turbo_codec_pkg::addr_t len_eff;
  turbo_codec_pkg::addr_t wr_pos;
  logic [3:0] sel_in;

  // a start beat while loading restarts the frame
  assign in_ready = (phase == turbo_codec_pkg::PH_IDLE) || (phase == turbo_codec_pkg::PH_LOAD);
  assign accept = in_valid && in_ready;
  assign frame_start = accept && in_beat.start;
  assign load_bit = accept && ((phase == turbo_codec_pkg::PH_LOAD) || in_beat.start);

  // selectors past the table fall back to pattern zero
  assign sel_in = (int'(puncture_pattern_select) < turbo_codec_pkg::PUNCT_IDS) ?
                  puncture_pattern_select : turbo_codec_pkg::PUNCT_DEFAULT;

  assign len_eff = frame_start ?
                   (signalling_mode ? turbo_codec_pkg::LEN_SIG : turbo_codec_pkg::LEN_DATA) :
                   turbo_block_length;
  assign wr_pos = frame_start ? '0 : wr_idx;
  assign last_in = load_bit && is_last(wr_pos, len_eff);

  assign scramble_eff = frame_start ? !signalling_mode : scramble_on;
  assign scrambled = in_beat.data ^ (scramble_eff & prbs_bit);

  prbs_scrambler u_prbs (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(frame_start),
    .step(load_bit),
    .prbs_bit(prbs_bit)
  );

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      turbo_block_length <= turbo_codec_pkg::LEN_DATA;
      pattern_sel <= turbo_codec_pkg::PUNCT_DEFAULT;
      scramble_on <= 1'b1;
      wr_idx <= '0;
    end
    else
    begin
      if (frame_start)
      begin
        turbo_block_length <= len_eff;
        pattern_sel <= sel_in;
        scramble_on <= !signalling_mode;
      end
      if (load_bit)
        wr_idx <= last_in ? '0 : wr_pos + 14'h0001;
    end
  end

  // no reset: every word is written before it is read
  always_ff @(posedge sys_clk)
  begin
    if (load_bit)
      frame_bits[wr_pos] <= scrambled;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // constituent encoders

  logic tail_phase;
  logic busy;
  logic x_nat;
  logic x_int;
  logic step_a;
  logic step_b;
  logic sx_a;
  logic pa_a;
  logic pb_a;
  logic sx_b;
  logic pa_b;
  logic pb_b;

  assign tail_phase = (phase == turbo_codec_pkg::PH_TAIL);
  assign busy = (phase == turbo_codec_pkg::PH_DATA) || tail_phase;
  assign perm_index = bit_idx;
  assign x_nat = frame_bits[bit_idx];
  // table answers out of range read as zero
  assign x_int = (perm_addr < turbo_block_length) ? frame_bits[perm_addr] : 1'b0;

  rsc_encoder u_enc_a (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(frame_start),
    .step(step_a),
    .terminate(tail_phase),
    .data_in(x_nat),
    .sym_x(sx_a),
    .parity_a_out(pa_a),
    .parity_b_out(pb_a)
  );

  rsc_encoder u_enc_b (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(frame_start),
    .step(step_b),
    .terminate(tail_phase),
    .data_in(x_int),
    .sym_x(sx_b),
    .parity_a_out(pa_b),
    .parity_b_out(pb_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // puncturing and symbol sequencing

  logic [5:0] cand;
  logic cand_bit;
  logic [1:0] count;
  logic can_issue;
  logic advance;
  logic emit;
  logic slot_done;
  logic period_end;
  logic last_data;
  logic first_half;

  assign cand = {sx_a, pa_a, pb_a, sx_b, pa_b, pb_b};
  assign cand_bit = cand[3'h5 - slot];
  assign count = turbo_codec_pkg::slot_count(tail_phase, pattern_sel,
                                             tail_phase ? {1'b0, tail_pos} : pattern_pos,
                                             slot);

  // a held output symbol freezes the whole encoder
  assign can_issue = !out_valid || out_ready;
  assign advance = busy && can_issue;
  assign emit = advance && (rep < count);
  assign slot_done = advance && ((count == 2'h0) || (rep == count - 2'h1));
  assign period_end = slot_done && (slot == turbo_codec_pkg::SLOT_LAST);
  assign last_data = is_last(bit_idx, turbo_block_length);
  assign first_half = (int'(tail_pos) < turbo_codec_pkg::TAIL_HALF);

  // data: both step together; tail: one steps while the other holds
  assign step_a = period_end && (!tail_phase || first_half);
  assign step_b = period_end && (!tail_phase || !first_half);

  // one slot per free cycle; tail copies hold the slot
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slot <= 3'h0;
      rep <= 2'h0;
    end
    else if (!busy)
    begin
      slot <= 3'h0;
      rep <= 2'h0;
    end
    else if (slot_done)
    begin
      slot <= (slot == turbo_codec_pkg::SLOT_LAST) ? 3'h0 : slot + 3'h1;
      rep <= 2'h0;
    end
    else if (emit)
      rep <= rep + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame sequencing

  // pattern position restarts with every block
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase <= turbo_codec_pkg::PH_IDLE;
      bit_idx <= '0;
      pattern_pos <= 4'h0;
      tail_pos <= 3'h0;
      block_done <= 1'b0;
    end
    else
    begin
      block_done <= 1'b0;
      case (phase)
        turbo_codec_pkg::PH_IDLE:
        begin
          if (frame_start)
            phase <= last_in ? turbo_codec_pkg::PH_DATA : turbo_codec_pkg::PH_LOAD;
          bit_idx <= '0;
          pattern_pos <= 4'h0;
          tail_pos <= 3'h0;
        end
        turbo_codec_pkg::PH_LOAD:
        begin
          if (last_in)
            phase <= turbo_codec_pkg::PH_DATA;
          bit_idx <= '0;
          pattern_pos <= 4'h0;
        end
        turbo_codec_pkg::PH_DATA:
        begin
          if (period_end)
          begin
            if (pattern_pos == turbo_codec_pkg::DATA_PERIODS[pattern_sel] - 4'h1)
              pattern_pos <= 4'h0;
            else
              pattern_pos <= pattern_pos + 4'h1;
            if (last_data)
            begin
              phase <= turbo_codec_pkg::PH_TAIL;
              bit_idx <= '0;
              tail_pos <= 3'h0;
            end
            else
              bit_idx <= bit_idx + 14'h0001;
          end
        end
        turbo_codec_pkg::PH_TAIL:
        begin
          if (period_end)
          begin
            if (tail_pos == turbo_codec_pkg::TAIL_LAST)
            begin
              phase <= turbo_codec_pkg::PH_IDLE;
              block_done <= 1'b1;
            end
            else
              tail_pos <= tail_pos + 3'h1;
          end
        end
        default:
        begin
          phase <= turbo_codec_pkg::PH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output register

  // marks the first symbol of each block
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      first_sym <= 1'b0;
    else if (phase == turbo_codec_pkg::PH_LOAD && last_in)
      first_sym <= 1'b1;
    else if (phase == turbo_codec_pkg::PH_IDLE && frame_start && last_in)
      first_sym <= 1'b1;
    else if (emit)
      first_sym <= 1'b0;
  end

  // data from flops; valid holds until taken
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_sym <= '0;
    end
    else if (can_issue)
    begin
      out_valid <= emit;
      if (emit)
      begin
        out_sym.data <= cand_bit;
        out_sym.start <= first_sym;
      end
    end
  end

endmodule

// file: verification/turbo_port_checker_sva.sv
module turbo_port_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic signalling_mode,
  input wire logic [3:0] puncture_pattern_select,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire turbo_codec_pkg::in_beat_s in_beat,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire turbo_codec_pkg::out_sym_s out_sym,
  input wire turbo_codec_pkg::addr_t perm_index,
  input wire turbo_codec_pkg::addr_t perm_addr,
  input wire logic block_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  chk_sym_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_sym))
    else $error("symbol changed while stalled");
  chk_index_step: assert property (
    !$stable(perm_index) |-> perm_index == $past(perm_index) + 14'h1 || perm_index == 14'h0)
    else $error("bit index jumped");
  chk_index_range: assert property (
    perm_index < turbo_codec_pkg::LEN_DATA)
    else $error("bit index beyond block");
  chk_first_index: assert property (
    out_valid && out_sym.start |-> perm_index == 14'h0)
    else $error("block start away from first period");
  chk_load_ready: assert property (
    in_valid && in_ready && in_beat.start |=> in_ready)
    else $error("not ready after frame start");
  chk_ready_rise: assert property (
    $rose(in_ready) |-> block_done || $past(block_done))
    else $error("ready without block end");
  chk_stall_freeze: assert property (
    out_valid && !out_ready |=> $stable(perm_index))
    else $error("encoder moved while stalled");
  chk_done_gap: assert property (
    block_done |=> !block_done [*8])
    else $error("block end pulses too close");
endmodule

// file: verification/downstream_model.sv
module downstream_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire turbo_codec_pkg::addr_t perm_index,
  output turbo_codec_pkg::addr_t perm_addr,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase;

  // pair swap table, a permutation for even block lengths
  assign perm_addr = perm_index ^ 14'h1;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase <= 3'h0;
      out_ready <= 1'b1;
    end
    else
    begin
      phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
      out_ready <= !(stall && phase < 3'h2);
    end
  end
endmodule

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH %0t value differs", $time); end end

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic signalling_mode = 1'b1;
  logic [3:0] puncture_pattern_select = 4'h0;
  logic in_valid = 1'b0;
  turbo_codec_pkg::in_beat_s in_beat = '0;
  logic stall = 1'b0;
  logic in_ready, out_valid, out_ready, block_done;
  turbo_codec_pkg::out_sym_s out_sym;
  turbo_codec_pkg::addr_t perm_index, perm_addr;
  turbo_codec_pkg::out_sym_s got[$], exp[$];
  logic u[12282];
  int n_fail = 0;
  int total_checks = 0;
  int n_done = 0;
  localparam logic [71:0] PAT[12] = '{{6'h3b, 66'h0}, {6'h2b, 6'h3b, 6'h39, 6'h3b, 48'h0},
    {6'h39, 6'h33, 60'h0}, {6'h29, 6'h2b, 6'h29, 6'h39, 48'h0}, {6'h32, 66'h0},
    {6'h29, 66'h0}, {6'h20, 6'h24, 6'h20, {3{6'h29, 6'h29, 6'h09}}},
    {6'h32, 6'h12, 6'h32, 6'h32, 6'h12, 6'h20, {2{6'h32, 6'h12, 6'h32}}},
    {6'h30, 6'h22, 60'h0}, {6'h22, 6'h30, 60'h0}, {6'h20, 6'h20, 6'h20, 6'h28, 48'h0},
    {6'h20, 6'h29, 6'h20, 6'h20, 48'h0}};
  localparam int PER[12] = '{1, 4, 2, 4, 1, 1, 12, 12, 2, 2, 4, 4};

  always #5 sys_clk = ~sys_clk;

  frame_scrambler_turbo_encoder dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .signalling_mode(signalling_mode), .puncture_pattern_select(puncture_pattern_select),
    .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat), .out_valid(out_valid),
    .out_ready(out_ready), .out_sym(out_sym), .perm_index(perm_index),
    .perm_addr(perm_addr), .block_done(block_done));
  downstream_model partner (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
    .perm_index(perm_index), .perm_addr(perm_addr), .out_ready(out_ready));

  always @(posedge sys_clk)
    if (out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back(out_sym);

  always @(posedge sys_clk)
    if (block_done === 1'b1)
      n_done++;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic raw(int i);
    logic [31:0] v;
    v = 32'(i) * 32'h9e3779b1;
    return v[20];
  endfunction

  function automatic void put(logic v);
    exp.push_back('{data: v, start: exp.size() == 0});
  endfunction

  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    in_valid <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    got.delete();
    n_done = 0;
  endtask

  task automatic send(logic md, logic [3:0] sel, int n, logic st);
    logic [14:0] r;
    logic pb;
    r = 15'h4a80;
    for (int i = 0; i < n; i++)
    begin
      pb = r[1] ^ r[0];
      r = {pb, r[14:1]};
      u[i] = raw(i) ^ (pb & !md);
      @(posedge sys_clk);
      signalling_mode <= md;
      puncture_pattern_select <= sel;
      in_valid <= 1'b1;
      in_beat <= '{data: raw(i), start: st && i == 0};
    end
    @(posedge sys_clk);
    in_valid <= 1'b0;
  endtask

  task automatic build(int sel, int len, bit full);
    logic [2:0] a, b;
    logic [5:0] c;
    logic wa, wb;
    int p;
    exp.delete();
    a = 3'h0;
    b = 3'h0;
    p = 0;
    for (int k = 0; k < len; k++)
    begin
      wa = u[k] ^ a[1] ^ a[2];
      wb = u[k ^ 1] ^ b[1] ^ b[2];
      c = {u[k], wa ^ a[0] ^ a[2], wa ^ (^a), u[k ^ 1], wb ^ b[0] ^ b[2], wb ^ (^b)};
      for (int s = 0; s < 6; s++)
        if (PAT[sel][71 - 6 * p - s])
          put(c[5 - s]);
      p = (p + 1) % PER[sel];
      a = {a[1:0], wa};
      b = {b[1:0], wb};
    end
    for (int t = 0; full && t < 6; t++)
    begin
      c[2:0] = (t < 3) ? a : b;
      repeat (3) put(c[1] ^ c[2]);
      put(c[0] ^ c[2]);
      put(^c[2:0]);
      if (t < 3)
        a = {a[1:0], 1'b0};
      else
        b = {b[1:0], 1'b0};
    end
  endtask

  task automatic check_first(int n);
    int t;
    t = 0;
    while (got.size() < n && t < 20000)
    begin
      @(posedge sys_clk);
      t++;
    end
    #1;
    `CHK(got.size() >= n, 1'b1)
    for (int i = 0; i < n; i++)
      `CHK(got[i], exp[i])
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_full();
    do_reset();
    stall <= 1'b1;
    send(1'b1, 4'h0, 1146, 1'b1);
    build(0, 1146, 1'b1);
    `CHK(exp.size(), 5760)
    check_first(5760);
    repeat (20) @(posedge sys_clk);
    `CHK(got.size(), 5760)
    `CHK(n_done, 1)
    `CHK(in_ready, 1'b1)
    stall <= 1'b0;
  endtask

  task automatic t_sels();
    for (int s = 0; s < 13; s++)
    begin
      do_reset();
      send(1'b1, 4'(s), 1146, 1'b1);
      build(s > 11 ? 0 : s, 1146, 1'b0);
      check_first(60);
    end
  endtask

  task automatic t_scr();
    do_reset();
    send(1'b0, 4'h4, 12282, 1'b1);
    build(4, 12282, 1'b0);
    check_first(60);
  endtask

  task automatic t_restart();
    do_reset();
    send(1'b1, 4'h0, 3, 1'b0);
    send(1'b1, 4'h0, 10, 1'b1);
    send(1'b1, 4'h5, 1146, 1'b1);
    build(5, 1146, 1'b0);
    check_first(60);
    do_reset();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    do_reset();
    t_full();
    t_sels();
    t_scr();
    t_restart();
    stop_test();
  end

  initial
  begin
    #900000;
    n_fail++;
    stop_test();
  end
endmodule

bind frame_scrambler_turbo_encoder turbo_port_checker chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .signalling_mode(signalling_mode),
  .puncture_pattern_select(puncture_pattern_select), .in_valid(in_valid),
  .in_ready(in_ready), .in_beat(in_beat), .out_valid(out_valid), .out_ready(out_ready),
  .out_sym(out_sym), .perm_index(perm_index), .perm_addr(perm_addr),
  .block_done(block_done));
